// ### hw/pmx_mclk_gen.sv
// Fractional divider making the 13 or 26 MHz master clock
`default_nettype none
`include "pmx_params.svh"
module pmx_mclk_gen (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic run_i,
  input  wire logic fast_i,
  output logic      mclk_o
);
  localparam int W = `PMX_ACC_W;
  localparam logic [W-1:0] STEP_HI = W'(2 * `PMX_MCLK_HI_MHZ);
  localparam logic [W-1:0] STEP_LO = W'(2 * `PMX_MCLK_LO_MHZ);
  localparam logic [W-1:0] MODULUS = W'(`PMX_CLK_MHZ);

  logic [W-1:0] acc;
  logic [W-1:0] step;
  logic [W-1:0] sum;

  // Exact mean rate; edges jitter by one core cycle since 250 is no multiple
  assign step = fast_i ? STEP_HI : STEP_LO;
  assign sum  = acc + step;

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || !run_i)
    begin
      acc    <= '0;
      mclk_o <= 1'b0;
    end
    else if (sum >= MODULUS)
    begin
      acc    <= sum - MODULUS;
      mclk_o <= ~mclk_o;
    end
    else
    begin
      acc <= sum;
    end
  end
endmodule : pmx_mclk_gen
`default_nettype wire

// ### hw/pmx_top.sv
// Pin-function multiplexer with clock output and reset pin states
`default_nettype none
`include "pmx_params.svh"
module pmx_top #(
  parameter int unsigned BLINK_DIV = `PMX_BLINK_CYC
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  cfg_valid_i,
  input  wire pmx_pkg::pmx_cfg_type  cfg_req_i,
  output logic                       cfg_ack_o,
  output logic                       cfg_reject_o,
  input  wire logic [8:0]            pin_in_i,
  output logic [8:0]                 pin_out_o,
  output logic [8:0]                 pin_oe_o,
  output logic [8:0]                 pin_pd_o,
  input  wire logic [8:0]            gp_level_i,
  output logic [8:0]                 gp_in_level_o,
  input  wire pmx_pkg::pmx_net_type  net_state_i,
  input  wire logic                  gnss_supply_en_i,
  input  wire logic                  gnss_rtc_sync_i,
  output logic                       gnss_data_ready_o,
  output logic                       sim_present_o,
  output logic                       sim_if_enable_o,
  input  wire logic                  aud_enable_i,
  input  wire logic                  aud_i2s_mode_i,
  input  wire logic                  aud_bit_tick_i,
  input  wire logic                  aud_tx_bit_i,
  output logic                       aud_rx_bit_o,
  input  wire logic                  mclk_fast_i,
  input  wire logic                  mclk_continuous_i,
  output logic                       mclk_o,
  output logic                       mclk_oe_o,
  input  wire logic                  dsr_level_i,
  output logic                       dsr_out_o,
  output logic                       dsr_oe_o,
  output logic                       dsr_pu_o
);
  localparam int NP = `PMX_NPIN;

  pmx_pkg::pmx_func_type [NP-1:0] pin_func;
  pmx_pkg::pmx_pin_type           drv [NP];
  logic [NP-1:0]                  in_s1;
  logic [NP-1:0]                  in_s;
  logic [NP-1:0]                  in_d;
  logic                           cfg_ok;
  logic [31:0]                    blink_cnt;
  logic                           blink_tick;
  logic [1:0]                     blink_div4;
  logic                           blink_fast;
  logic                           blink_slow;
  logic                           net_level;
  logic                           aud_bclk;
  logic [4:0]                     aud_bit;
  logic [4:0]                     next_aud_bit;
  logic                           aud_wa;
  logic                           aud_txd;
  logic                           mclk_run;

  function automatic logic allowed(input logic [3:0] p,
                                   input pmx_pkg::pmx_func_type f);
    if (p >= 4'(NP))
      allowed = 1'b0;
    else
      case (f)
        pmx_pkg::FN_NET,
        pmx_pkg::FN_GNSS_PWR: allowed = p <= 4'(`PMX_PIN_G4);
        pmx_pkg::FN_GNSS_RDY: allowed = p == 4'(`PMX_PIN_G3);
        pmx_pkg::FN_GNSS_RTC: allowed = p == 4'(`PMX_PIN_G4);
        pmx_pkg::FN_SIM_DET,
        pmx_pkg::FN_SIM_HOT:  allowed = p == 4'(`PMX_PIN_G5);
        pmx_pkg::FN_AUDIO:    allowed = p >= 4'(`PMX_PIN_ATX);
        pmx_pkg::FN_OFF,
        pmx_pkg::FN_GP_IN,
        pmx_pkg::FN_GP_OUT:   allowed = 1'b1;
        default:              allowed = 1'b0;
      endcase
  endfunction : allowed

  assign cfg_ok = allowed(cfg_req_i.pin, cfg_req_i.func);

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      pin_func                 <= {NP{pmx_pkg::FN_AUDIO}};
      pin_func[`PMX_PIN_G1]    <= pmx_pkg::FN_OFF;
      pin_func[`PMX_PIN_G2]    <= pmx_pkg::FN_GNSS_PWR;
      pin_func[`PMX_PIN_G3]    <= pmx_pkg::FN_GNSS_RDY;
      pin_func[`PMX_PIN_G4]    <= pmx_pkg::FN_GP_OUT;
      pin_func[`PMX_PIN_G5]    <= pmx_pkg::FN_SIM_DET;
    end
    else if (cfg_valid_i && cfg_ok)
    begin
      pin_func[cfg_req_i.pin] <= cfg_req_i.func;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      cfg_ack_o    <= 1'b0;
      cfg_reject_o <= 1'b0;
    end
    else
    begin
      cfg_ack_o    <= cfg_valid_i && cfg_ok;
      cfg_reject_o <= cfg_valid_i && !cfg_ok;
    end
  end

  // Pins are asynchronous; third stage only feeds edge detection
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      in_s1 <= '0;
      in_s  <= '0;
      in_d  <= '0;
    end
    else
    begin
      in_s1 <= pin_in_i;
      in_s  <= in_s1;
      in_d  <= in_s;
    end
  end

  assign blink_tick = blink_cnt == BLINK_DIV - 1;

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || blink_tick)
      blink_cnt <= '0;
    else
      blink_cnt <= blink_cnt + 32'h1;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      blink_div4 <= 2'h0;
      blink_fast <= 1'b0;
      blink_slow <= 1'b0;
    end
    else if (blink_tick)
    begin
      blink_div4 <= blink_div4 + 2'h1;
      blink_fast <= ~blink_fast;
      if (blink_div4 == 2'h3)
        blink_slow <= ~blink_slow;
    end
  end

  // Steady on home, slow blink roaming, fast blink data, off without service
  always_comb
  begin
    case (net_state_i)
      pmx_pkg::NET_HOME: net_level = 1'b1;
      pmx_pkg::NET_ROAM: net_level = blink_slow;
      pmx_pkg::NET_DATA: net_level = blink_fast;
      default:           net_level = 1'b0;
    endcase
  end

  assign next_aud_bit = aud_bit + 5'h01;

  // Bit launched as the bit clock falls; PCM sync one bit, I2S half frame
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || !aud_enable_i)
    begin
      aud_bclk <= 1'b0;
      aud_bit  <= 5'h00;
      aud_wa   <= 1'b0;
      aud_txd  <= 1'b0;
    end
    else if (aud_bit_tick_i)
    begin
      aud_bclk <= ~aud_bclk;
      if (aud_bclk)
      begin
        aud_bit <= next_aud_bit;
        aud_txd <= aud_tx_bit_i;
        aud_wa  <= aud_i2s_mode_i ? next_aud_bit[`PMX_AUD_CH_BIT]
                                  : next_aud_bit == 5'h00;
      end
    end
  end

  always_comb
  begin
    for (int i = 0; i < NP; i++)
    begin
      drv[i] = '{out: 1'b0, oe: 1'b0, pd: 1'b1};
      case (pin_func[i])
        pmx_pkg::FN_GP_OUT:
          drv[i] = '{out: gp_level_i[i], oe: 1'b1, pd: 1'b0};
        pmx_pkg::FN_NET:
          drv[i] = '{out: net_level, oe: 1'b1, pd: 1'b0};
        pmx_pkg::FN_GNSS_PWR:
          drv[i] = '{out: gnss_supply_en_i, oe: 1'b1, pd: 1'b0};
        pmx_pkg::FN_GNSS_RTC:
          drv[i] = '{out: gnss_rtc_sync_i, oe: 1'b1, pd: 1'b0};
        pmx_pkg::FN_GP_IN,
        pmx_pkg::FN_GNSS_RDY,
        pmx_pkg::FN_SIM_DET,
        pmx_pkg::FN_SIM_HOT:
          drv[i].pd = 1'b0;
        pmx_pkg::FN_AUDIO:
          case (i)
            `PMX_PIN_ATX:  drv[i] = '{out: aud_txd, oe: 1'b1, pd: 1'b0};
            `PMX_PIN_ACLK: drv[i] = '{out: aud_bclk, oe: 1'b1, pd: 1'b0};
            `PMX_PIN_AWA:  drv[i] = '{out: aud_wa, oe: 1'b1, pd: 1'b0};
            default:       drv[i].pd = 1'b0;
          endcase
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      pin_out_o <= '0;
      pin_oe_o  <= '0;
      pin_pd_o  <= '1;
    end
    else
      for (int i = 0; i < NP; i++)
      begin
        pin_out_o[i] <= drv[i].out;
        pin_oe_o[i]  <= drv[i].oe;
        pin_pd_o[i]  <= drv[i].pd;
      end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      gp_in_level_o     <= '0;
      gnss_data_ready_o <= 1'b0;
      sim_present_o     <= 1'b0;
      aud_rx_bit_o      <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < NP; i++)
        gp_in_level_o[i] <= pin_func[i] == pmx_pkg::FN_GP_IN
                            && in_s[i];
      gnss_data_ready_o <= pin_func[`PMX_PIN_G3] == pmx_pkg::FN_GNSS_RDY
                           && in_s[`PMX_PIN_G3];
      sim_present_o <= (pin_func[`PMX_PIN_G5] == pmx_pkg::FN_SIM_DET
                        || pin_func[`PMX_PIN_G5] == pmx_pkg::FN_SIM_HOT)
                       && in_s[`PMX_PIN_G5];
      aud_rx_bit_o <= in_s[`PMX_PIN_ARX];
    end
  end

  // Enable holds its last value outside hot-plug mode
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      sim_if_enable_o <= 1'b0;
    else if (pin_func[`PMX_PIN_G5] == pmx_pkg::FN_SIM_HOT
             && in_s[`PMX_PIN_G5] != in_d[`PMX_PIN_G5])
      sim_if_enable_o <= in_s[`PMX_PIN_G5];
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      dsr_out_o <= 1'b0;
      dsr_oe_o  <= 1'b0;
      dsr_pu_o  <= 1'b1;
      mclk_oe_o <= 1'b0;
    end
    else
    begin
      dsr_out_o <= dsr_level_i;
      dsr_oe_o  <= 1'b1;
      dsr_pu_o  <= 1'b0;
      mclk_oe_o <= 1'b1;
    end
  end

  assign mclk_run = mclk_continuous_i || aud_enable_i;

  pmx_mclk_gen u_mclk (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .run_i      (mclk_run),
    .fast_i     (mclk_fast_i),
    .mclk_o     (mclk_o)
  );

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_rst_pins;
    @(posedge core_clk_i) disable iff (1'b0)
    sys_rst_i |=> pin_oe_o == '0 && pin_pd_o == '1;
  endproperty
  a_rst_pins: assert property (p_rst_pins)
    else $error("pins not parked");
  property p_rst_dsr;
    @(posedge core_clk_i) disable iff (1'b0)
    sys_rst_i |=> !dsr_oe_o && dsr_pu_o;
  endproperty
  a_rst_dsr: assert property (p_rst_dsr)
    else $error("dsr not parked");
  property p_cfg_take;
    cfg_valid_i && cfg_ok |=> cfg_ack_o
      && pin_func[$past(cfg_req_i.pin)] == $past(cfg_req_i.func);
  endproperty
  a_cfg_take: assert property (p_cfg_take) else $error("cfg lost");
  property p_cfg_reject;
    cfg_valid_i && !cfg_ok |=> cfg_reject_o && $stable(pin_func);
  endproperty
  a_cfg_reject: assert property (p_cfg_reject) else $error("bad cfg");
  // Sampled reset is still high at the release edge
  property p_gp_out;
    !sys_rst_i && pin_func[`PMX_PIN_G4] == pmx_pkg::FN_GP_OUT
      |=> pin_oe_o[`PMX_PIN_G4]
      && pin_out_o[`PMX_PIN_G4] == $past(gp_level_i[`PMX_PIN_G4]);
  endproperty
  a_gp_out: assert property (p_gp_out) else $error("gp out");
  property p_off;
    pin_func[`PMX_PIN_G1] == pmx_pkg::FN_OFF
      |=> !pin_oe_o[`PMX_PIN_G1] && pin_pd_o[`PMX_PIN_G1];
  endproperty
  a_off: assert property (p_off) else $error("pin not off");
  property p_hot;
    pin_func[`PMX_PIN_G5] == pmx_pkg::FN_SIM_HOT
      && in_s[`PMX_PIN_G5] != in_d[`PMX_PIN_G5]
      |=> sim_if_enable_o == $past(in_s[`PMX_PIN_G5]);
  endproperty
  a_hot: assert property (p_hot) else $error("sim hot plug");
  property p_mclk_fast;
    mclk_run && mclk_fast_i && $changed(mclk_o)
      |=> (!$changed(mclk_o) || !$past(mclk_run)) [*3];
  endproperty
  a_mclk_fast: assert property (p_mclk_fast) else $error("mclk fast");
  property p_mclk_stop;
    !mclk_run [*2] |-> !mclk_o;
  endproperty
  a_mclk_stop: assert property (p_mclk_stop) else $error("mclk runs");
  property p_aud_sync;
    aud_enable_i && aud_bit_tick_i && aud_bclk |=> aud_wa ==
      ($past(aud_i2s_mode_i) ? aud_bit[`PMX_AUD_CH_BIT] : aud_bit == 5'h00);
  endproperty
  a_aud_sync: assert property (p_aud_sync) else $error("word align");

  c_reject: cover property (cfg_valid_i && !cfg_ok);
  c_hot_in: cover property (pin_func[`PMX_PIN_G5] == pmx_pkg::FN_SIM_HOT
                            && $rose(sim_if_enable_o));
  c_mclk:   cover property (mclk_run && mclk_fast_i && $rose(mclk_o));
  c_pcm:    cover property (!aud_i2s_mode_i && $rose(aud_wa));
endmodule : pmx_top
`default_nettype wire

// ### shared/pmx_params.svh
// Constants for the pin-function multiplexer
`ifndef PMX_PARAMS_SVH
`define PMX_PARAMS_SVH
`define PMX_NPIN        9
`define PMX_PIN_G1      0
`define PMX_PIN_G2      1
`define PMX_PIN_G3      2
`define PMX_PIN_G4      3
`define PMX_PIN_G5      4
`define PMX_PIN_ATX     5
`define PMX_PIN_ARX     6
`define PMX_PIN_ACLK    7
`define PMX_PIN_AWA     8
`define PMX_CLK_MHZ     250
`define PMX_MCLK_LO_MHZ 13
`define PMX_MCLK_HI_MHZ 26
`define PMX_ACC_W       9
`define PMX_BLINK_MS    100
`define PMX_BLINK_CYC   (`PMX_BLINK_MS * 1000 * `PMX_CLK_MHZ)
`define PMX_AUD_CH_BIT  4
`endif

// ### shared/pmx_pkg.sv
// Types for the pin-function multiplexer
`default_nettype none
package pmx_pkg;
  typedef enum logic [3:0] {
    FN_OFF, FN_GP_IN, FN_GP_OUT, FN_NET, FN_GNSS_PWR, FN_GNSS_RDY,
    FN_GNSS_RTC, FN_SIM_DET, FN_SIM_HOT, FN_AUDIO
  } pmx_func_type;
  typedef enum logic [1:0] {
    NET_NONE, NET_HOME, NET_ROAM, NET_DATA
  } pmx_net_type;
  typedef struct packed {
    logic [3:0]   pin;
    pmx_func_type func;
  } pmx_cfg_type;
  typedef struct packed {
    logic out;
    logic oe;
    logic pd;
  } pmx_pin_type;
endpackage : pmx_pkg
`default_nettype wire

// ### test/pmx_far_model.sv
// Far side of the nine pins: codec, GNSS receiver, SIM holder
`default_nettype none
module pmx_far_model (
  input  wire logic       core_clk_i,
  input  wire logic [8:0] pin_out_i,
  input  wire logic [8:0] pin_oe_i,
  input  wire logic [8:0] pin_pd_i,
  input  wire logic [8:0] ext_en_i,
  input  wire logic [8:0] ext_lvl_i,
  output logic      [8:0] pin_in_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] last = 9'h000;
  // Floating pins wander, so no check can lean on a stale level
  always_comb
  begin
    for (int i = 0; i < 9; i++)
    begin
      if (pin_oe_i[i])
        pin_in_o[i] = pin_out_i[i];
      else if (ext_en_i[i])
        pin_in_o[i] = ext_lvl_i[i];
      else if (pin_pd_i[i])
        pin_in_o[i] = 1'b0;
      else
        pin_in_o[i] = ~last[i];
    end
  end
  always_ff @(posedge core_clk_i)
    last <= pin_in_o;
endmodule : pmx_far_model
`default_nettype wire

// ### test/pmx_top_bench.sv
// Self-checking bench for the pin-function multiplexer
`default_nettype none
module pmx_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  cfg_valid = 1'b0;
  pmx_pkg::pmx_cfg_type  cfg_req = 8'h00;
  logic                  ack, rej, mclk, mclk_oe, rdy, sim_pres, sim_en;
  logic                  rx_bit, dsr_out, dsr_oe, dsr_pu;
  logic [8:0]            p_out, p_oe, p_pd, p_in, gp_in;
  logic [8:0]            gp_lvl = 9'h000, ext_lvl = 9'h000;
  logic [8:0]            ext_en = 9'h1FF;
  pmx_pkg::pmx_net_type  net = pmx_pkg::NET_HOME;
  logic                  sup_en = 1'b0, rtc = 1'b0, tx_bit = 1'b0;
  logic                  aud_en = 1'b0, i2s = 1'b0, tick = 1'b0;
  logic                  fast = 1'b0, cont = 1'b0, dsr_lvl = 1'b0;
  pmx_pkg::pmx_func_type cur [9];
  int                    miscompares = 0, n_checks = 0, cycles = 0;
  int                    seed = 32'h11714E87;

  pmx_top #(.BLINK_DIV(4)) u_pmx_top (
    .core_clk_i(clk), .sys_rst_i(rst), .cfg_valid_i(cfg_valid),
    .cfg_req_i(cfg_req), .cfg_ack_o(ack), .cfg_reject_o(rej),
    .pin_in_i(p_in), .pin_out_o(p_out), .pin_oe_o(p_oe), .pin_pd_o(p_pd),
    .gp_level_i(gp_lvl), .gp_in_level_o(gp_in), .net_state_i(net),
    .gnss_supply_en_i(sup_en), .gnss_rtc_sync_i(rtc),
    .gnss_data_ready_o(rdy), .sim_present_o(sim_pres),
    .sim_if_enable_o(sim_en), .aud_enable_i(aud_en),
    .aud_i2s_mode_i(i2s), .aud_bit_tick_i(tick), .aud_tx_bit_i(tx_bit),
    .aud_rx_bit_o(rx_bit), .mclk_fast_i(fast), .mclk_continuous_i(cont),
    .mclk_o(mclk), .mclk_oe_o(mclk_oe), .dsr_level_i(dsr_lvl),
    .dsr_out_o(dsr_out), .dsr_oe_o(dsr_oe), .dsr_pu_o(dsr_pu)
  );

  pmx_far_model u_pmx_far_model (
    .core_clk_i(clk), .pin_out_i(p_out), .pin_oe_i(p_oe), .pin_pd_i(p_pd),
    .ext_en_i(ext_en), .ext_lvl_i(ext_lvl), .pin_in_o(p_in)
  );

  always #2 clk = ~clk;

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // Bounds a hang; the whole run needs far fewer cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic chk_bits(input logic [8:0] exp, input logic [8:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk_bits

  task automatic chk_cnt(input int exp, input int got);
    n_checks++;
    if (got != exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk_cnt

  // Permitted pins per function code, in package enum order
  function automatic logic legal(input int p, input int f);
    case (f)
      0, 1, 2: return p < 9;
      3, 4: return p < 4;
      5: return p == 2;
      6: return p == 3;
      7, 8: return p == 4;
      9: return p > 4 && p < 9;
      default: return 1'b0;
    endcase
  endfunction : legal

  task automatic stir;
    @(posedge clk);
    gp_lvl <= 9'($random(seed));
    ext_lvl <= 9'($random(seed));
    sup_en <= 1'($random(seed));
    rtc <= 1'($random(seed));
    tx_bit <= 1'($random(seed));
    dsr_lvl <= 1'($random(seed));
    net <= ($random(seed) & 1) ? pmx_pkg::NET_HOME : pmx_pkg::NET_NONE;
  endtask : stir

  task automatic send(input int pin, input int fn);
    logic ok;
    ok = legal(pin, fn);
    @(posedge clk);
    cfg_valid <= 1'b1;
    cfg_req <= {4'(pin), 4'(fn)};
    @(posedge clk);
    cfg_valid <= 1'b0;
    @(negedge clk);
    chk_bits({7'h00, ok, ~ok}, {7'h00, ack, rej});
    if (ok)
      cur[pin] = pmx_pkg::pmx_func_type'(fn);
  endtask : send

  // Inputs pass two sync flops and an output flop, so four edges just suffice
  task automatic pin_chk(input int p);
    stir();
    repeat (4) @(negedge clk);
    case (cur[p])
      pmx_pkg::FN_OFF:
        chk_bits(9'h001, {7'h00, p_oe[p], p_pd[p]});
      pmx_pkg::FN_GP_OUT:
        chk_bits({8'h01, gp_lvl[p]}, {7'h00, p_oe[p], p_out[p]});
      pmx_pkg::FN_GP_IN:
        chk_bits({8'h00, ext_lvl[p]}, {8'h00, gp_in[p]});
      pmx_pkg::FN_NET:
        chk_bits({8'h01, net == pmx_pkg::NET_HOME},
                 {7'h00, p_oe[p], p_out[p]});
      pmx_pkg::FN_GNSS_PWR:
        chk_bits({8'h01, sup_en}, {7'h00, p_oe[p], p_out[p]});
      pmx_pkg::FN_GNSS_RTC:
        chk_bits({8'h01, rtc}, {7'h00, p_oe[p], p_out[p]});
      pmx_pkg::FN_GNSS_RDY:
        chk_bits({8'h00, ext_lvl[2]}, {8'h00, rdy});
      pmx_pkg::FN_SIM_DET:
        chk_bits({8'h00, ext_lvl[4]}, {8'h00, sim_pres});
      default: ;
    endcase
    chk_bits({5'h00, dsr_lvl, 3'h6},
             {5'h00, dsr_out, dsr_oe, mclk_oe, dsr_pu});
  endtask : pin_chk

  task automatic net_cnt(input pmx_pkg::pmx_net_type s, input int exp);
    logic prev;
    int   n;
    n = 0;
    @(posedge clk);
    net <= s;
    repeat (4) @(negedge clk);
    prev = p_out[0];
    // Blink periods divide the window, so any start phase gives the count
    repeat (64)
    begin
      @(negedge clk);
      if (p_out[0] !== prev)
        n++;
      prev = p_out[0];
    end
    chk_cnt(exp, n);
  endtask : net_cnt

  task automatic mclk_cnt(input logic f, input logic c, input logic a,
                          input int exp);
    logic prev;
    int   n;
    n = 0;
    @(posedge clk);
    fast <= f;
    cont <= c;
    aud_en <= a;
    repeat (20) @(negedge clk);
    prev = mclk;
    // 250 cycles is one microsecond: toggles are twice the MHz figure
    repeat (250)
    begin
      @(negedge clk);
      if (mclk !== prev)
        n++;
      prev = mclk;
    end
    chk_cnt(exp, n);
  endtask : mclk_cnt

  task automatic aud_run(input logic m, input int exp_wa);
    int   nb;
    int   nw;
    logic prev7;
    nb = 0;
    nw = 0;
    @(posedge clk);
    aud_en <= 1'b1;
    i2s <= m;
    tick <= 1'b1;
    repeat (20) @(negedge clk);
    prev7 = p_out[7];
    // Exactly four 32-bit frames, so phase does not matter
    repeat (256)
    begin
      @(negedge clk);
      if (p_out[7] === 1'b0 && prev7 === 1'b1)
      begin
        nb++;
        if (p_out[8] === 1'b1)
          nw++;
      end
      prev7 = p_out[7];
    end
    chk_cnt(128, nb);
    chk_cnt(exp_wa, nw);
    chk_bits({7'h00, tx_bit, ext_lvl[6]}, {7'h00, p_out[5], rx_bit});
    @(posedge clk);
    aud_en <= 1'b0;
    tick <= 1'b0;
  endtask : aud_run

  initial
  begin
    cur = '{pmx_pkg::FN_OFF, pmx_pkg::FN_GNSS_PWR, pmx_pkg::FN_GNSS_RDY,
            pmx_pkg::FN_GP_OUT, pmx_pkg::FN_SIM_DET, pmx_pkg::FN_AUDIO,
            pmx_pkg::FN_AUDIO, pmx_pkg::FN_AUDIO, pmx_pkg::FN_AUDIO};
    repeat (12) @(posedge clk);
    @(negedge clk);
    chk_bits(9'h000, p_oe);
    chk_bits(9'h1FF, p_pd);
    chk_bits(9'h001, {6'h00, dsr_oe, mclk_oe, dsr_pu});
    @(posedge clk);
    rst <= 1'b0;
    for (int p = 0; p < 5; p++)
      pin_chk(p);
    for (int p = 0; p < 10; p++)
      for (int f = 0; f < 11; f++)
      begin
        send(p, f);
        if (p < 9)
          pin_chk(p);
      end
    repeat (30)
    begin
      send({$random(seed)} % 9, {$random(seed)} % 9);
      pin_chk(cfg_req.pin);
    end
    send(0, 3);
    net_cnt(pmx_pkg::NET_DATA, 16);
    net_cnt(pmx_pkg::NET_ROAM, 4);
    for (int p = 5; p < 9; p++)
      send(p, 9);
    send(4, 8);
    // Park the card pin low first; enable only moves on an edge
    @(posedge clk);
    ext_lvl[4] <= 1'b0;
    repeat (5) @(negedge clk);
    @(posedge clk);
    ext_lvl[4] <= 1'b1;
    repeat (5) @(negedge clk);
    chk_bits(9'h001, {8'h00, sim_en});
    @(posedge clk);
    ext_lvl[4] <= 1'b0;
    repeat (5) @(negedge clk);
    chk_bits(9'h000, {8'h00, sim_en});
    mclk_cnt(1'b1, 1'b1, 1'b0, 52);
    mclk_cnt(1'b0, 1'b1, 1'b0, 26);
    mclk_cnt(1'b1, 1'b0, 1'b0, 0);
    mclk_cnt(1'b0, 1'b0, 1'b1, 26);
    aud_run(1'b1, 64);
    aud_run(1'b0, 4);
    tally_and_finish();
  end
endmodule : pmx_top_bench
`default_nettype wire
